/* File: logic/uce_uart.sv */
// serial port with double-buffered transmitter and console mode entry
`timescale 1ns/1ps
`default_nettype none
// Contract
// - transmitter has a shift stage and a holding buffer for the next byte
// - status bit 2 shows holding buffer empty, high means ready for a byte
// - status bit 1 shows shifter empty, low while a character shifts out
// - transmit write keeps the low byte and drops holding-empty
// - buffered byte moves to shifter on its own, holding-empty rises again
// - each received character lands in the receive buffer low byte
// - status bit 7 is the OR of overrun, framing and parity errors
// - status bits 6, 5, 4 are overrun, framing and parity error
// - status bit 0 is data ready, rising when a character completes
// - reading the receive buffer returns the eight bits in the low byte
// - status bit 3 mirrors the console request input
// - console request high at the first edge after reset release enters console mode
// - breakpoint reads status, bit 4 low makes it a no-operation
// - breakpoint with bit 4 high enters console mode, awaits a command
// - console mode starts the console program on this serial port
// - commands start with letters for examine, modify, continue or run
// - console program examines, modifies, continues or runs anywhere
// - link is 9600 baud, 8 data bits, odd parity, one stop bit
module uce_uart (
  input  wire logic        mclk,          // system clock, 250 MHz
  input  wire logic        rst_b,         // sync master reset, active low
  input  wire logic        timClk,        // timer clock, sets the baud rate
  input  wire logic [15:0] xioAddr,       // i/o instruction address
  input  wire logic        xioWr,         // output instruction strobe
  input  wire logic        xioRd,         // input instruction strobe
  input  wire logic [15:0] xioWdata,      // source register value
  output logic      [15:0] xioRdata,      // destination register value
  output logic             xioAck,        // pulse: read data valid
  input  wire logic        rxLine,        // serial receive line
  output logic             txLine,        // serial transmit line
  input  wire logic        consoleReq,    // console request discrete
  input  wire logic        bptExec,       // pulse: breakpoint executes
  output logic             bptNop,        // pulse: breakpoint ignored
  output logic             consoleEnter,  // pulse: start console program
  input  wire logic        consoleExit,   // pulse: continue or run done
  output logic             consoleMode,   // level: console mode active
  output logic             cmdValid,      // pulse: console command letter
  output uce_pkg::uce_cmd_e cmdCode       // decoded command letter
);

  // timer clock edge gives the sampling tick of both directions
  logic timPrev_reg;
  wire  baudTick = timClk && !timPrev_reg;

  // ---------------- register access decode ----------------
  wire selStatus = (xioAddr == uce_pkg::XIO_STATUS);
  wire selRxBuf  = (xioAddr == uce_pkg::XIO_RXBUF);
  wire selTxBuf  = (xioAddr == uce_pkg::XIO_TXBUF);
  wire txWrite   = xioWr && selTxBuf;
  wire rxRead    = xioRd && selRxBuf;

  // ---------------- transmitter state ----------------
  uce_pkg::uce_line_e txState_reg;
  uce_pkg::uce_line_e txState_next;
  logic [7:0] hold_reg;
  logic [7:0] shift_reg;
  logic       holdEmpty_reg;
  logic       shiftEmpty_reg;
  logic [3:0] txTick_reg;
  logic [2:0] txBit_reg;
  logic       txPar_reg;

  wire bitEnd  = baudTick && (txTick_reg == uce_pkg::TICKS_PER_BIT);
  wire txMove  = (txState_reg == uce_pkg::LN_IDLE) && !holdEmpty_reg;
  wire txLast  = (txBit_reg == uce_pkg::LAST_DATA_BIT);

  // ---------------- receiver state ----------------
  uce_pkg::uce_rxchar_s rxChar;
  logic                 rxDone;
  logic [7:0]           rxBuf_reg;
  logic                 dataReady_reg;
  logic                 overrun_reg;
  logic                 framing_reg;
  logic                 parity_reg;

  // ---------------- console state ----------------
  logic bootCheck_reg;
  logic consoleMode_reg;
  uce_pkg::uce_status_s status;

  assign status.dataReady  = dataReady_reg;
  assign status.shiftEmpty = shiftEmpty_reg;
  assign status.holdEmpty  = holdEmpty_reg;
  assign status.consoleReq = consoleReq;
  assign status.parityErr  = parity_reg;
  assign status.framingErr = framing_reg;
  assign status.overrunErr = overrun_reg;
  assign status.rxErrSum   = overrun_reg | framing_reg | parity_reg;

  // console-enable shares bit 4 with the parity flag; the breakpoint
  // looks at whatever the status word holds there at that moment
  wire consoleEnable = status.parityErr;
  wire bptEnter      = bptExec && consoleEnable;
  wire bootEnter     = bootCheck_reg && consoleReq;

  // upper-case letters only; anything else is unknown
  wire [7:0] cmdChar = rxChar.data;
  wire cmdE = (cmdChar == uce_pkg::ASC_EXAMINE);
  wire cmdM = (cmdChar == uce_pkg::ASC_MODIFY);
  wire cmdC = (cmdChar == uce_pkg::ASC_CONTINUE);
  wire cmdR = (cmdChar == uce_pkg::ASC_RUN);
  wire cmdGood = !(rxChar.framingErr || rxChar.parityErr);
  uce_pkg::uce_cmd_e cmdDecoded;
  assign cmdDecoded = cmdE ? uce_pkg::CMD_EXAMINE  :
                      cmdM ? uce_pkg::CMD_MODIFY   :
                      cmdC ? uce_pkg::CMD_CONTINUE :
                      cmdR ? uce_pkg::CMD_RUN      :
                             uce_pkg::CMD_UNKNOWN;

  wire [15:0] rdMux = selStatus ? {8'h00, status}   :
                      selRxBuf  ? {8'h00, rxBuf_reg} :
                                  uce_pkg::WORD_RST;

  uce_rx_frame u_rx (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .baudTick (baudTick),
    .rxLine   (rxLine),
    .rxChar   (rxChar),
    .rxDone   (rxDone)
  );

  // ---------------- transmitter sequencing ----------------
  always_comb begin
    txState_next = txState_reg;
    unique case (txState_reg)
      uce_pkg::LN_IDLE:   if (txMove) txState_next = uce_pkg::LN_START;
      uce_pkg::LN_START:  if (bitEnd) txState_next = uce_pkg::LN_DATA;
      uce_pkg::LN_DATA:   if (bitEnd && txLast)
                            txState_next = uce_pkg::LN_PARITY;
      uce_pkg::LN_PARITY: if (bitEnd) txState_next = uce_pkg::LN_STOP;
      uce_pkg::LN_STOP:   if (bitEnd) txState_next = uce_pkg::LN_IDLE;
      default:            txState_next = uce_pkg::LN_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      timPrev_reg <= 1'b0;
      txState_reg <= uce_pkg::LN_IDLE;
    end else begin
      timPrev_reg <= timClk;
      txState_reg <= txState_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      txTick_reg  <= uce_pkg::TICK_RST;
      txBit_reg   <= uce_pkg::BIT_RST;
      txPar_reg   <= 1'b0;
    end else begin
      if (txState_reg == uce_pkg::LN_IDLE)
        txTick_reg <= uce_pkg::TICK_RST;
      else if (baudTick)
        txTick_reg <= bitEnd ? uce_pkg::TICK_RST : txTick_reg + 4'h1;
      if (txMove) begin
        txBit_reg <= uce_pkg::BIT_RST;
        txPar_reg <= uce_pkg::uce_odd_parity(hold_reg);
      end else if (bitEnd && txState_reg == uce_pkg::LN_DATA) begin
        txBit_reg <= txBit_reg + 3'h1;
      end
    end
  end

  // the pin follows the state being entered, so each bit edge is one
  // register stage from its tick (two stages between data bits) and never glitches
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      txLine <= 1'b1;
    end else begin
      unique case (txState_next)
        uce_pkg::LN_START:  txLine <= 1'b0;
        uce_pkg::LN_DATA:   txLine <= shift_reg[0];
        uce_pkg::LN_PARITY: txLine <= txPar_reg;
        default:            txLine <= 1'b1;
      endcase
    end
  end

  // holding buffer and shifter; a write in the same cycle as the move
  // refills the holding buffer, so the write's empty-low wins
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hold_reg       <= uce_pkg::BYTE_RST;
      shift_reg      <= uce_pkg::BYTE_RST;
      holdEmpty_reg  <= 1'b1;
      shiftEmpty_reg <= 1'b1;
    end else begin
      if (txWrite) begin
        hold_reg      <= xioWdata[7:0];
        holdEmpty_reg <= 1'b0;
      end else if (txMove) begin
        holdEmpty_reg <= 1'b1;
      end
      if (txMove) begin
        shift_reg      <= hold_reg;
        shiftEmpty_reg <= 1'b0;
      end else begin
        if (bitEnd && txState_reg == uce_pkg::LN_DATA)
          shift_reg <= {1'b0, shift_reg[7:1]};
        if (bitEnd && txState_reg == uce_pkg::LN_STOP)
          shiftEmpty_reg <= 1'b1;
      end
    end
  end

  // ---------------- receive buffer and flags ----------------
  // a character finishing in the read cycle keeps data ready set
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rxBuf_reg     <= uce_pkg::BYTE_RST;
      dataReady_reg <= 1'b0;
      overrun_reg   <= 1'b0;
      framing_reg   <= 1'b0;
      parity_reg    <= 1'b0;
    end else begin
      if (rxDone) begin
        rxBuf_reg     <= rxChar.data;
        framing_reg   <= rxChar.framingErr;
        parity_reg    <= rxChar.parityErr;
        overrun_reg   <= dataReady_reg && !rxRead;
        dataReady_reg <= 1'b1;
      end else if (rxRead) begin
        dataReady_reg <= 1'b0;
      end
    end
  end

  // ---------------- processor read path ----------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      xioAck <= 1'b0;
    end else begin
      xioAck <= xioRd;
    end
  end

  // read data holds until the next read, as software may sample it late
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      xioRdata <= uce_pkg::WORD_RST;
    end else if (xioRd) begin
      xioRdata <= rdMux;
    end
  end

  // ---------------- console entry ----------------
  // the request pin is caught on the first edge after reset release,
  // so it must still be high then
  wire enterReq   = bootEnter || bptEnter;
  wire enterPulse = enterReq && !consoleMode_reg;
  wire nopPulse   = bptExec && !consoleEnable;
  wire cmdTake    = rxDone && consoleMode_reg && cmdGood;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bootCheck_reg <= 1'b1;
    end else begin
      bootCheck_reg <= 1'b0;
    end
  end

  // entry wins over a simultaneous exit, so a breakpoint is never lost
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      consoleMode_reg <= 1'b0;
    end else if (enterReq) begin
      consoleMode_reg <= 1'b1;
    end else if (consoleExit) begin
      consoleMode_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      consoleEnter <= 1'b0;
      bptNop       <= 1'b0;
    end else begin
      consoleEnter <= enterPulse;
      bptNop       <= nopPulse;
    end
  end

  // command letters are flagged only while the console program listens
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cmdValid <= 1'b0;
      cmdCode  <= uce_pkg::CMD_NONE;
    end else begin
      cmdValid <= cmdTake;
      if (cmdTake)
        cmdCode <= cmdDecoded;
    end
  end

  // the console program itself reaches registers and memories
  assign consoleMode = consoleMode_reg;

endmodule : uce_uart
`default_nettype wire

/* File: logic/uce_pkg.sv */
// shared constants, types and helpers for the serial port with console entry
`default_nettype none
package uce_pkg;

  // processor i/o addresses of the three port registers
  localparam logic [15:0] XIO_STATUS = 16'hFFFE;
  localparam logic [15:0] XIO_RXBUF  = 16'hFFFF;
  localparam logic [15:0] XIO_TXBUF  = 16'h7FFF;

  // status bit positions
  localparam int unsigned ST_DATA_READY   = 0;
  localparam int unsigned ST_SHIFT_EMPTY  = 1;
  localparam int unsigned ST_HOLD_EMPTY   = 2;
  localparam int unsigned ST_CONSOLE_REQ  = 3;
  localparam int unsigned ST_PARITY_ERR   = 4;
  localparam int unsigned ST_FRAMING_ERR  = 5;
  localparam int unsigned ST_OVERRUN_ERR  = 6;
  localparam int unsigned ST_RX_ERR_SUM   = 7;

  // line format and timing
  localparam int unsigned BAUD_RATE      = 9600;
  localparam int unsigned DATA_BITS      = 8;
  localparam logic [3:0]  TICKS_PER_BIT  = 4'hF;  // timer edges per bit - 1
  localparam logic [3:0]  TICKS_HALF_BIT = 4'h7;  // to mid of start bit
  localparam logic [2:0]  LAST_DATA_BIT  = 3'h7;

  // reset values
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [3:0]  TICK_RST  = 4'h0;
  localparam logic [2:0]  BIT_RST   = 3'h0;

  // console command letters, upper case only
  localparam logic [7:0] ASC_EXAMINE  = 8'h45;
  localparam logic [7:0] ASC_MODIFY   = 8'h4D;
  localparam logic [7:0] ASC_CONTINUE = 8'h43;
  localparam logic [7:0] ASC_RUN      = 8'h52;

  typedef enum logic [2:0] {
    CMD_NONE     = 3'b000,
    CMD_EXAMINE  = 3'b001,
    CMD_MODIFY   = 3'b010,
    CMD_CONTINUE = 3'b011,
    CMD_RUN      = 3'b100,
    CMD_UNKNOWN  = 3'b101
  } uce_cmd_e;

  typedef enum logic [2:0] {
    LN_IDLE   = 3'b000,
    LN_START  = 3'b001,
    LN_DATA   = 3'b010,
    LN_PARITY = 3'b011,
    LN_STOP   = 3'b100
  } uce_line_e;

  typedef struct packed {
    logic rxErrSum;
    logic overrunErr;
    logic framingErr;
    logic parityErr;
    logic consoleReq;
    logic holdEmpty;
    logic shiftEmpty;
    logic dataReady;
  } uce_status_s;

  typedef struct packed {
    logic [7:0] data;
    logic       framingErr;
    logic       parityErr;
  } uce_rxchar_s;

  // parity bit that makes the count of ones in data plus parity odd
  function automatic logic uce_odd_parity(input logic [7:0] d);
    uce_odd_parity = ~(^d);
  endfunction : uce_odd_parity

endpackage : uce_pkg
`default_nettype wire

/* File: logic/uce_rx_frame.sv */
// serial receiver: start detect, 8 data bits, odd parity, one stop bit
`timescale 1ns/1ps
`default_nettype none
module uce_rx_frame (
  input  wire logic                 mclk,      // system clock
  input  wire logic                 rst_b,     // sync reset, active low
  input  wire logic                 baudTick,  // one pulse per timer edge
  input  wire logic                 rxLine,    // serial input, idle high
  output uce_pkg::uce_rxchar_s      rxChar,    // last finished character
  output logic                      rxDone     // pulse: character finished
);

  uce_pkg::uce_line_e state_reg;
  uce_pkg::uce_line_e state_next;
  logic [3:0]         tick_reg;
  logic [2:0]         bit_reg;
  logic [7:0]         shift_reg;
  logic               parOk_reg;

  wire sampleNow = baudTick && (tick_reg == TICKS_LAST(state_reg));
  wire lastBit   = (bit_reg == uce_pkg::LAST_DATA_BIT);

  // state is an argument so the continuous assignment sees its changes
  function automatic logic [3:0] TICKS_LAST(input uce_pkg::uce_line_e s);
    TICKS_LAST = (s == uce_pkg::LN_START) ?
                 uce_pkg::TICKS_HALF_BIT : uce_pkg::TICKS_PER_BIT;
  endfunction : TICKS_LAST

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      uce_pkg::LN_IDLE:   if (!rxLine) state_next = uce_pkg::LN_START;
      uce_pkg::LN_START: begin
        // a glitch shorter than half a bit is dropped
        if (sampleNow) state_next = rxLine ? uce_pkg::LN_IDLE
                                            : uce_pkg::LN_DATA;
      end
      uce_pkg::LN_DATA:   if (sampleNow && lastBit)
                            state_next = uce_pkg::LN_PARITY;
      uce_pkg::LN_PARITY: if (sampleNow) state_next = uce_pkg::LN_STOP;
      uce_pkg::LN_STOP:   if (sampleNow) state_next = uce_pkg::LN_IDLE;
      default:            state_next = uce_pkg::LN_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= uce_pkg::LN_IDLE;
      tick_reg  <= uce_pkg::TICK_RST;
      bit_reg   <= uce_pkg::BIT_RST;
      shift_reg <= uce_pkg::BYTE_RST;
      parOk_reg <= 1'b1;
      rxChar    <= '0;
      rxDone    <= 1'b0;
    end else begin
      state_reg <= state_next;
      rxDone    <= 1'b0;
      if (state_reg == uce_pkg::LN_IDLE) begin
        tick_reg <= uce_pkg::TICK_RST;
        bit_reg  <= uce_pkg::BIT_RST;
      end else if (baudTick) begin
        tick_reg <= sampleNow ? uce_pkg::TICK_RST : tick_reg + 4'h1;
      end
      if (sampleNow && state_reg == uce_pkg::LN_DATA) begin
        shift_reg <= {rxLine, shift_reg[7:1]};  // lsb first
        bit_reg   <= bit_reg + 3'h1;
      end
      if (sampleNow && state_reg == uce_pkg::LN_PARITY)
        parOk_reg <= (rxLine == uce_pkg::uce_odd_parity(shift_reg));
      if (sampleNow && state_reg == uce_pkg::LN_STOP) begin
        rxChar.data       <= shift_reg;
        rxChar.framingErr <= !rxLine;
        rxChar.parityErr  <= !parOk_reg;
        rxDone            <= 1'b1;
      end
    end
  end

endmodule : uce_rx_frame
`default_nettype wire

/* File: verification/uce_uart_checker.sv */
// port-level assertions for the serial port with console entry
`timescale 1ns/1ps
`default_nettype none
module uce_uart_checker (
  input wire logic              mclk,         // system clock
  input wire logic              rst_b,        // sync reset, active low
  input wire logic              timClk,       // timer clock
  input wire logic [15:0]       xioAddr,      // i/o address
  input wire logic              xioWr,        // write strobe
  input wire logic              xioRd,        // read strobe
  input wire logic [15:0]       xioWdata,     // write data
  input wire logic [15:0]       xioRdata,     // read data
  input wire logic              xioAck,       // read answer
  input wire logic              rxLine,       // serial in
  input wire logic              txLine,       // serial out
  input wire logic              consoleReq,   // console request
  input wire logic              bptExec,      // breakpoint pulse
  input wire logic              bptNop,       // breakpoint ignored
  input wire logic              consoleEnter, // console start pulse
  input wire logic              consoleExit,  // console leave pulse
  input wire logic              consoleMode,  // console level
  input wire logic              cmdValid,     // command letter pulse
  input wire uce_pkg::uce_cmd_e cmdCode       // decoded letter
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_rd_taken;
    xioRd;
  endsequence
  sequence s_rd_answer;
    xioAck && xioRdata[15:8] == 8'h00;
  endsequence
  sequence s_status_rd;
    xioRd && xioAddr == uce_pkg::XIO_STATUS;
  endsequence

  a_read_answer: assert property (s_rd_taken |=> s_rd_answer)
    else $error("read not answered with clean high byte");
  a_ack_cause: assert property (xioAck |-> $past(xioRd))
    else $error("answer without a read");
  a_status_bits: assert property (s_status_rd |=>
    xioRdata[3] == $past(consoleReq) && xioRdata[7] == |xioRdata[6:4])
    else $error("status summary or console bit wrong");
  a_unmapped_zero: assert property (xioRd
    && xioAddr != uce_pkg::XIO_STATUS && xioAddr != uce_pkg::XIO_RXBUF
    && xioAddr != uce_pkg::XIO_TXBUF |=> xioRdata == 16'h0000)
    else $error("unmapped read not zero");
  a_bpt_one_answer: assert property (
    bptExec && !consoleMode |=> bptNop != consoleEnter)
    else $error("breakpoint needs exactly one answer");
  a_no_reenter: assert property (
    bptExec && consoleMode && !consoleExit |=> !consoleEnter && consoleMode)
    else $error("console entered twice");
  a_mode_cause: assert property (
    $rose(consoleMode) |-> consoleEnter)
    else $error("console mode without entry pulse");
  a_exit_clears: assert property (
    consoleExit && consoleMode && !bptExec |=> !consoleMode)
    else $error("console mode not left");
  a_boot_entry: assert property (
    rst_b && !$past(rst_b) && consoleReq |=> consoleMode && consoleEnter)
    else $error("no console entry at reset");
  a_cmd_decoded: assert property (cmdValid |-> consoleMode
    && cmdCode != uce_pkg::CMD_NONE)
    else $error("command pulse without code");
endmodule : uce_uart_checker
bind uce_uart uce_uart_checker chk_u (.mclk(mclk), .rst_b(rst_b),
  .timClk(timClk), .xioAddr(xioAddr), .xioWr(xioWr), .xioRd(xioRd),
  .xioWdata(xioWdata), .xioRdata(xioRdata), .xioAck(xioAck),
  .rxLine(rxLine), .txLine(txLine), .consoleReq(consoleReq),
  .bptExec(bptExec), .bptNop(bptNop), .consoleEnter(consoleEnter),
  .consoleExit(consoleExit), .consoleMode(consoleMode),
  .cmdValid(cmdValid), .cmdCode(cmdCode));
`default_nettype wire

/* File: verification/uce_term.sv */
// terminal model: sends framed characters and captures the port's output
`timescale 1ns/1ps
`default_nettype none
module uce_term (
  input  wire logic timClk, // tick source, 16 ticks a bit
  input  wire logic txLine, // port output
  output logic      rxLine  // port input, idle high
);
  logic [7:0] rxQ[$];
  int         badFrm = 0;
  initial rxLine = 1'b1;
  task automatic ticks(input int n);
    repeat (n) @(posedge timClk);
  endtask : ticks
  // broken parity or stop only when a scenario asks for it
  task automatic send(input logic [7:0] d, input logic bp, input logic bs);
    logic [10:0] f;
    f = {~bs, ~(^d) ^ bp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxLine <= f[i];
      ticks(16);
    end
    rxLine <= 1'b1;
  endtask : send
  initial begin
    logic [9:0] s;
    forever begin
      @(negedge txLine);
      ticks(8);
      if (txLine !== 1'b0) badFrm++;
      for (int i = 0; i < 10; i++) begin
        ticks(16);
        s[i] = txLine;
      end
      if (s[8] !== ~(^s[7:0]) || s[9] !== 1'b1) badFrm++;
      rxQ.push_back(s[7:0]);
    end
  end
endmodule : uce_term
`default_nettype wire

/* File: verification/uce_uart_test.sv */
// self-checking bench for the serial port with console entry
`timescale 1ns/1ps
`default_nettype none
module uce_uart_test;
  logic              mclk = 1'b0;
  logic              rst_b = 1'b0;
  logic              timClk = 1'b0;
  logic [15:0]       xioAddr = 16'h0000;
  logic              xioWr = 1'b0;
  logic              xioRd = 1'b0;
  logic [15:0]       xioWdata = 16'h0000;
  logic [15:0]       xioRdata;
  logic              xioAck;
  wire logic         rxLine;
  logic              txLine;
  logic              consoleReq = 1'b1;
  logic              bptExec = 1'b0;
  logic              bptNop;
  logic              consoleEnter;
  logic              consoleExit = 1'b0;
  logic              consoleMode;
  logic              cmdValid;
  uce_pkg::uce_cmd_e cmdCode;
  uce_pkg::uce_cmd_e lastCmd = uce_pkg::CMD_NONE;
  int                seed = 14840;
  int                error_cnt = 0;
  int                checked = 0;
  int                cyc = 0;
  logic [2:0]        div = 3'h0;
  logic [15:0]       rdv;
  logic [7:0]        b;
  logic [7:0]        txExp[$];
  logic [7:0] cmdCh[5] = '{uce_pkg::ASC_EXAMINE, uce_pkg::ASC_MODIFY,
    uce_pkg::ASC_CONTINUE, uce_pkg::ASC_RUN, 8'h65};
  uce_pkg::uce_cmd_e cmdExp[5] = '{uce_pkg::CMD_EXAMINE, uce_pkg::CMD_MODIFY,
    uce_pkg::CMD_CONTINUE, uce_pkg::CMD_RUN, uce_pkg::CMD_UNKNOWN};

  uce_uart dut_u (.mclk(mclk), .rst_b(rst_b), .timClk(timClk),
    .xioAddr(xioAddr), .xioWr(xioWr), .xioRd(xioRd), .xioWdata(xioWdata),
    .xioRdata(xioRdata), .xioAck(xioAck), .rxLine(rxLine), .txLine(txLine),
    .consoleReq(consoleReq), .bptExec(bptExec), .bptNop(bptNop),
    .consoleEnter(consoleEnter), .consoleExit(consoleExit),
    .consoleMode(consoleMode), .cmdValid(cmdValid), .cmdCode(cmdCode));
  uce_term term_u (.timClk(timClk), .txLine(txLine), .rxLine(rxLine));

  initial begin
    forever #2 mclk = ~mclk;
  end
  // timer far above the line rate: frames stay short, ratios unchanged
  always @(posedge mclk) begin
    div <= div + 3'h1;
    timClk <= div[2];
    cyc <= cyc + 1;
    if (cmdValid === 1'b1) lastCmd <= cmdCode;
    if (cyc == 40000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    xioAddr <= a;
    xioRd <= 1'b1;
    @(posedge mclk);
    xioRd <= 1'b0;
    #1;
    chk("ack", {15'h0, xioAck}, 16'h0001);
    d = xioRdata;
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    xioAddr <= a;
    xioWdata <= d;
    xioWr <= 1'b1;
    @(posedge mclk);
    xioWr <= 1'b0;
  endtask : wr
  function automatic logic [15:0] st(input logic dr, oe, fe, pe);
    st = {8'h00, oe | fe | pe, oe, fe, pe, consoleReq, 2'b11, dr};
  endfunction : st
  task automatic waitSt(input int n, input logic v);
    int k;
    k = 0;
    rd(uce_pkg::XIO_STATUS, rdv);
    while (rdv[n] !== v && k < 3000) begin
      rd(uce_pkg::XIO_STATUS, rdv);
      k++;
    end
    chk("status poll", {15'h0, rdv[n]}, {15'h0, v});
  endtask : waitSt
  task automatic rxCheck(input logic [7:0] d, input logic oe, fe, pe);
    waitSt(0, 1'b1);
    chk("rx status", rdv, st(1'b1, oe, fe, pe));
    rd(uce_pkg::XIO_RXBUF, rdv);
    chk("rx buffer", rdv, {8'h00, d});
    rd(uce_pkg::XIO_STATUS, rdv);
    chk("ready clear", rdv, st(1'b0, oe, fe, pe));
  endtask : rxCheck
  task automatic breakpoint_instruction(input logic nop, input logic ent);
    @(posedge mclk);
    bptExec <= 1'b1;
    @(posedge mclk);
    bptExec <= 1'b0;
    #1;
    chk("bpt nop", {15'h0, bptNop}, {15'h0, nop});
    chk("bpt enter", {consoleEnter, consoleMode}, {ent, ent});
  endtask : breakpoint_instruction
  task automatic leave();
    @(posedge mclk);
    consoleExit <= 1'b1;
    @(posedge mclk);
    consoleExit <= 1'b0;
    consoleReq <= 1'b0;
    #1;
    chk("exit mode", {15'h0, consoleMode}, 16'h0000);
  endtask : leave
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    // the entry pulse stands only in the cycle after the first edge
    @(posedge mclk);
    #1;
    chk("boot mode", {consoleEnter, consoleMode}, 16'h0003);
    rd(16'h1234, rdv);
    chk("unmapped", rdv, 16'h0000);
    rd(uce_pkg::XIO_STATUS, rdv);
    chk("reset status", rdv, 16'h000E);
    // second byte waits in the holding buffer behind the first
    for (int i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      txExp.push_back(b);
      wr(uce_pkg::XIO_TXBUF, {~b, b});
    end
    rd(uce_pkg::XIO_STATUS, rdv);
    chk("tx busy", {14'h0, rdv[2:1]}, 16'h0000);
    waitSt(2, 1'b1);
    chk("tx shifting", {15'h0, rdv[1]}, 16'h0000);
    waitSt(1, 1'b1);
    chk("tx count", 16'(term_u.rxQ.size()), 16'h0002);
    foreach (txExp[i])
      chk("tx byte", {8'h00, term_u.rxQ[i]}, {8'h00, txExp[i]});
    chk("tx frame", 16'(term_u.badFrm), 16'h0000);
    foreach (cmdCh[i]) begin
      term_u.send(cmdCh[i], 1'b0, 1'b0);
      rxCheck(cmdCh[i], 1'b0, 1'b0, 1'b0);
      chk("command", {13'h0, lastCmd}, {13'h0, cmdExp[i]});
    end
    leave();
    breakpoint_instruction(1'b1, 1'b0);
    b = 8'($random(seed));
    term_u.send(b, 1'b1, 1'b0);
    rxCheck(b, 1'b0, 1'b0, 1'b1);
    breakpoint_instruction(1'b0, 1'b1);
    leave();
    b = 8'($random(seed));
    term_u.send(b, 1'b0, 1'b1);
    rxCheck(b, 1'b0, 1'b1, 1'b0);
    term_u.send(8'($random(seed)), 1'b0, 1'b0);
    b = 8'($random(seed));
    term_u.send(b, 1'b0, 1'b0);
    rxCheck(b, 1'b1, 1'b0, 1'b0);
    finish_test();
  end
endmodule : uce_uart_test
`default_nettype wire
